// ==== common/sar_adc_defs.vh ====
// constants for the converter sequencer: register indices, fields, timing
// assumes an APB slave with 32-bit data; byte address = index * 4
//
// Operation
// - convert the held sample to 10 bits by successive approximation
// - two-bit channel code 00..11 picks input four, five, six, seven
// - each terminal is analog when its enable bit is 1; reset gives port
// - clock code 000..110 divides fast oscillator by 1..64; 111 slow osc
// - prescaler clock reaches the converter only while the gate bit is 1
// - writing 1 to the start bit begins one conversion of the channel; a 1 written while busy is dropped
// - sampling begins after the start delay; approximation follows it
// - the 10-bit result loads at the end; bit 0 lsb, bit 9 msb
// - done flag sets on every stored result, whatever enable or priority
// - request only when flag, enable, and priority above cpu level
// - writing 1 to the done flag clears it; 0 leaves it
// - completion interrupt uses vector address 000024H
// - one conversion lasts at least 11 us at a 2 MHz clock
// - start bit is write-only; writing 0 does nothing; reads 0
// - reset: clock select 000, gate, channel and enable all 0
// - low result byte holds bits 1:0; bits 7:2 read 0
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

// register indices as printed; byte address is four times the index
`define IDX_CLOCK_CTRL   8'h80
`define IDX_PIN_CTRL     8'h81
`define IDX_CONV_CTRL    8'h82
`define IDX_RESULT_HI    8'h83
`define IDX_RESULT_LO    8'h84
`define IDX_IRQ_PRIO     8'h28
`define IDX_IRQ_ENABLE   8'h2a
`define IDX_IRQ_FLAG     8'h2c

// field positions
`define F_CLOCK_SEL_LO   0
`define F_CLOCK_SEL_HI   2
`define F_CLOCK_GATE     3
`define F_PIN_EN_LO      4
`define F_PIN_EN_HI      7
`define F_CHAN_LO        0
`define F_CHAN_HI        1
`define F_START          7
`define F_PRIO_LO        6
`define F_PRIO_HI        7
`define F_IRQ_ENABLE     7
`define F_DONE_FLAG      7

// reset values
`define RST_CLOCK_SEL    3'h0
`define RST_CLOCK_GATE   1'h0
`define RST_PIN_EN       4'h0
`define RST_CHAN         2'h0
`define RST_PRIO         2'h0
`define RST_IRQ_ENABLE   1'h0
`define RST_RESULT       10'h000

// clock select code that picks the slow oscillator
`define SEL_SLOW_OSC     3'h7

// conversion vector address
`define CONV_VECTOR      24'h000024

// conversion timing: time in ns, reference in kHz, counts in conversion-clock ticks
`define CONV_TIME_NS     11000
`define CONV_REF_KHZ     2000
`define CONV_TICKS       ((`CONV_TIME_NS * `CONV_REF_KHZ) / 1000000)
`define RESULT_BITS      10
`define DELAY_TICKS      4'h2
`define SAMPLE_TICKS     4'ha
`define SAR_MSB_TRIAL    10'h200

`endif

// ==== rtl/adc_prescaler.v ====
// conversion clock prescaler: divides fast ticks by 2^sel, or passes slow
// assumes fast_tick and slow_tick are one-cycle pulses already synchronised
`include "sar_adc_defs.vh"

module adc_prescaler (
  input  wire       clk,
  input  wire       reset,
  input  wire       fast_tick,
  input  wire       slow_tick,
  input  wire [2:0] sel,
  input  wire       gate,
  output reg        tick
);

  reg  [5:0] div;
  wire [5:0] mask;

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_mask
      localparam [2:0] K = i;
      assign mask[i] = (sel > K);
    end
  endgenerate

  always @(posedge clk) begin
    if (reset) begin
      div  <= 6'h00;
      tick <= 1'b0;
    end else begin
      if (fast_tick)
        div <= div + 6'h01;
      if (!gate)
        tick <= 1'b0;
      else if (sel == `SEL_SLOW_OSC)
        tick <= slow_tick;
      else
        tick <= fast_tick && ((div & mask) == mask);
    end
  end

endmodule

// ==== rtl/adc_sar_core.v ====
// successive-approximation sequencer: delay, sample, ten compare steps
// assumes step is a one-cycle tick and comp_high means input above dac
`include "sar_adc_defs.vh"

module adc_sar_core (
  input  wire       clk,
  input  wire       reset,
  input  wire       start,
  input  wire       step,
  input  wire       comp_high,
  output reg        busy,
  output reg        sample,
  output reg        done,
  output reg  [9:0] dac_code,
  output reg  [9:0] result
);

  localparam [3:0] S_IDLE   = 4'h1;
  localparam [3:0] S_DELAY  = 4'h2;
  localparam [3:0] S_SAMPLE = 4'h4;
  localparam [3:0] S_CONV   = 4'h8;

  reg  [3:0] state;
  reg  [3:0] count;
  reg  [9:0] trial;
  wire [9:0] kept = comp_high ? dac_code : (dac_code & ~trial);

  always @(posedge clk) begin
    if (reset) begin
      state    <= S_IDLE;
      count    <= 4'h0;
      trial    <= 10'h000;
      busy     <= 1'b0;
      sample   <= 1'b0;
      done     <= 1'b0;
      dac_code <= 10'h000;
      result   <= `RST_RESULT;
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: if (start) begin
          state <= S_DELAY;
          busy  <= 1'b1;
          count <= 4'h0;
        end
        S_DELAY: if (step) begin
          if (count == `DELAY_TICKS - 4'h1) begin
            state  <= S_SAMPLE;
            sample <= 1'b1;
            count  <= 4'h0;
          end else
            count <= count + 4'h1;
        end
        S_SAMPLE: if (step) begin
          if (count == `SAMPLE_TICKS - 4'h1) begin
            state    <= S_CONV;
            sample   <= 1'b0;
            trial    <= `SAR_MSB_TRIAL;
            dac_code <= `SAR_MSB_TRIAL;
          end else
            count <= count + 4'h1;
        end
        S_CONV: if (step) begin
          if (trial[0]) begin
            result   <= kept;
            done     <= 1'b1;
            busy     <= 1'b0;
            dac_code <= 10'h000;
            state    <= S_IDLE;
          end else begin
            trial    <= trial >> 1;
            dac_code <= kept | (trial >> 1);
          end
        end
        default: begin
          state  <= S_IDLE;
          busy   <= 1'b0;
          sample <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== rtl/sar_adc_sequencer.v ====
// top of the converter control: APB registers, pin mux, interrupt request
// assumes oscillators and comparator arrive asynchronously on pins
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`include "sar_adc_defs.vh"

module sar_adc_sequencer (
  input  wire        CLK,
  input  wire        RESET,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [9:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // clock sources
  input  wire        FAST_OSC,
  input  wire        SLOW_OSC,
  // analog front end
  input  wire        COMP_HIGH,
  output wire [9:0]  DAC_CODE,
  output wire        SAMPLE_HOLD,
  output reg  [3:0]  ANALOG_MUX_SEL,
  output reg  [3:0]  ANALOG_PIN_ENABLE,
  output wire        BUSY,
  // cpu interrupt controller
  input  wire [1:0]  CPU_LEVEL,
  output reg         IRQ_REQUEST,
  output reg  [23:0] IRQ_VECTOR
);

  // ---------------------------------------------------------------
  // pin synchronisers; the first stage feeds only the second
  // ---------------------------------------------------------------
  reg fast_meta;
  reg fast_sync;
  reg fast_prev;
  reg slow_meta;
  reg slow_sync;
  reg slow_prev;
  reg comp_meta;
  reg comp_sync;

  always @(posedge CLK) begin
    if (RESET) begin
      fast_meta <= 1'b0;
      fast_sync <= 1'b0;
      fast_prev <= 1'b0;
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      fast_meta <= FAST_OSC;
      fast_sync <= fast_meta;
      fast_prev <= fast_sync;
      slow_meta <= SLOW_OSC;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
      comp_meta <= COMP_HIGH;
      comp_sync <= comp_meta;
    end
  end

  // oscillator edges become one-cycle ticks; an oscillator above
  // half of CLK aliases, so such sources must be slower than that
  wire fast_tick = fast_sync & ~fast_prev;
  wire slow_tick = slow_sync & ~slow_prev;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  reg  [2:0] clock_sel;
  reg        clock_gate;
  reg  [3:0] pin_enable;
  reg  [1:0] chan_sel;
  reg  [1:0] irq_prio;
  reg        irq_enable;
  reg        done_flag;
  reg        conv_start;

  wire       conv_tick;
  wire       core_busy;
  wire       core_done;
  wire [9:0] result;

  // ---------------------------------------------------------------
  // apb handshake: one wait state, answer registered
  // ---------------------------------------------------------------
  wire [7:0] index  = PADDR[9:2];
  wire       pend   = PSEL & PENABLE & ~PREADY;
  wire       access = PSEL & PENABLE & PREADY;
  wire       wr     = access & PWRITE;

  reg [31:0] next_rdata;
  reg        next_mapped;

  always @* begin
    next_rdata  = 32'h00000000;
    next_mapped = 1'b1;
    case (index)
      `IDX_CLOCK_CTRL: begin
        next_rdata[`F_CLOCK_SEL_HI:`F_CLOCK_SEL_LO] = clock_sel;
        next_rdata[`F_CLOCK_GATE] = clock_gate;
      end
      `IDX_PIN_CTRL:
        next_rdata[`F_PIN_EN_HI:`F_PIN_EN_LO] = pin_enable;
      `IDX_CONV_CTRL:
        // start bit always reads back as zero
        next_rdata[`F_CHAN_HI:`F_CHAN_LO] = chan_sel;
      `IDX_RESULT_HI:
        next_rdata[7:0] = result[9:2];
      `IDX_RESULT_LO:
        next_rdata[1:0] = result[1:0];
      `IDX_IRQ_PRIO:
        next_rdata[`F_PRIO_HI:`F_PRIO_LO] = irq_prio;
      `IDX_IRQ_ENABLE:
        next_rdata[`F_IRQ_ENABLE] = irq_enable;
      `IDX_IRQ_FLAG:
        next_rdata[`F_DONE_FLAG] = done_flag;
      default: begin
        next_rdata  = 32'h00000000;
        next_mapped = 1'b0;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= pend;
      PSLVERR <= pend & ~next_mapped;
      if (pend)
        PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    if (RESET) begin
      clock_sel  <= `RST_CLOCK_SEL;
      clock_gate <= `RST_CLOCK_GATE;
      pin_enable <= `RST_PIN_EN;
      chan_sel   <= `RST_CHAN;
      irq_prio   <= `RST_PRIO;
      irq_enable <= `RST_IRQ_ENABLE;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (wr) begin
        case (index)
          `IDX_CLOCK_CTRL: begin
            clock_sel  <= PWDATA[`F_CLOCK_SEL_HI:`F_CLOCK_SEL_LO];
            clock_gate <= PWDATA[`F_CLOCK_GATE];
          end
          `IDX_PIN_CTRL:
            pin_enable <= PWDATA[`F_PIN_EN_HI:`F_PIN_EN_LO];
          `IDX_CONV_CTRL: begin
            chan_sel <= PWDATA[`F_CHAN_HI:`F_CHAN_LO];
            // a start during a running conversion is dropped
            conv_start <= PWDATA[`F_START] & ~core_busy;
          end
          `IDX_IRQ_PRIO:
            irq_prio <= PWDATA[`F_PRIO_HI:`F_PRIO_LO];
          `IDX_IRQ_ENABLE:
            irq_enable <= PWDATA[`F_IRQ_ENABLE];
          default: begin
            conv_start <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // completion flag; a new result wins over a clearing write
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    if (RESET)
      done_flag <= 1'b0;
    else if (core_done)
      done_flag <= 1'b1;
    else if (wr && index == `IDX_IRQ_FLAG && PWDATA[`F_DONE_FLAG])
      done_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // interrupt request and vector
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    if (RESET) begin
      IRQ_REQUEST <= 1'b0;
      IRQ_VECTOR  <= `CONV_VECTOR;
    end else begin
      IRQ_REQUEST <= done_flag & irq_enable & (irq_prio > CPU_LEVEL);
      IRQ_VECTOR  <= `CONV_VECTOR;
    end
  end

  // ---------------------------------------------------------------
  // terminal function and channel multiplexer
  // ---------------------------------------------------------------
  wire [3:0] next_mux;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      localparam [1:0] CODE = ch;
      // mux opens only while sampling; a disabled terminal still
      // connects, so the result is garbage as software was told
      assign next_mux[ch] = (chan_sel == CODE) & SAMPLE_HOLD;
    end
  endgenerate

  always @(posedge CLK) begin
    if (RESET) begin
      ANALOG_MUX_SEL    <= 4'h0;
      ANALOG_PIN_ENABLE <= `RST_PIN_EN;
    end else begin
      ANALOG_MUX_SEL    <= next_mux;
      ANALOG_PIN_ENABLE <= pin_enable;
    end
  end

  // ---------------------------------------------------------------
  // prescaler and conversion core
  // ---------------------------------------------------------------
  adc_prescaler u_prescaler (
    .clk       (CLK),
    .reset     (RESET),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick),
    .sel       (clock_sel),
    .gate      (clock_gate),
    .tick      (conv_tick)
  );

  // delay, sampling and ten steps give the conversion tick count;
  // the comparator sync adds two CLK cycles, so each tick must be
  // at least three CLK cycles apart for a settled decision
  adc_sar_core u_core (
    .clk       (CLK),
    .reset     (RESET),
    .start     (conv_start),
    .step      (conv_tick),
    .comp_high (comp_sync),
    .busy      (core_busy),
    .sample    (SAMPLE_HOLD),
    .done      (core_done),
    .dac_code  (DAC_CODE),
    .result    (result)
  );

  assign BUSY = core_busy;

endmodule

// ==== tb/adc_far_side.sv ====
// far side model: oscillators, four analog levels, comparator
// assumes the mux select pulses while its input is sampled
module adc_far_side (
  input  wire logic        clk,
  input  wire logic [3:0]  mux_sel,
  input  wire logic [3:0]  pin_en,
  input  wire logic [9:0]  dac_code,
  input  wire logic [39:0] levels,
  output logic             fast_osc,
  output logic             slow_osc,
  output wire logic        comp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  // half periods off the clock grid, so phase is unrelated
  // oscillators run settled from time zero; ideal comparator with no delay
  // tick rate scaled to the CLK grid, not to real frequencies
  initial begin
    fast_osc = 1'b0;
    forever #110 fast_osc = ~fast_osc;
  end
  initial begin
    slow_osc = 1'b0;
    forever #370 slow_osc = ~slow_osc;
  end
  // a port-mode terminal charges nothing into the hold stage
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++)
      if (mux_sel[i] && pin_en[i]) held <= levels[i*10 +: 10];
  end
  // half-step offset: a trial equal to the level keeps its bit
  assign comp_high = {held, 1'b1} > {dac_code, 1'b0};
endmodule

// ==== tb/sar_adc_sequencer_asserts.sv ====
// port checker for the converter sequencer
// assumes apb byte address = index * 4, bound below
module sar_adc_checker (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [9:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [9:0]  DAC_CODE,
  input wire logic        SAMPLE_HOLD,
  input wire logic [3:0]  ANALOG_MUX_SEL,
  input wire logic [3:0]  ANALOG_PIN_ENABLE,
  input wire logic        BUSY,
  input wire logic [1:0]  CPU_LEVEL,
  input wire logic        IRQ_REQUEST,
  input wire logic [23:0] IRQ_VECTOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // shadows of writable fields, taken at write completion
  logic       wr;
  logic [1:0] chan;
  logic [1:0] prio;
  logic       en;
  logic [3:0] pins;
  logic [7:0] len;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      chan <= 2'h0;
      prio <= 2'h0;
      en   <= 1'h0;
      pins <= 4'h0;
    end else if (wr) begin
      if (PADDR[9:2] == 8'h82) chan <= PWDATA[1:0];
      if (PADDR[9:2] == 8'h28) prio <= PWDATA[7:6];
      if (PADDR[9:2] == 8'h2a) en <= PWDATA[7];
      if (PADDR[9:2] == 8'h81) pins <= PWDATA[7:4];
    end
  end
  // saturates so long slow conversions cannot wrap
  always_ff @(posedge CLK) begin
    if (RESET || !BUSY) len <= 8'h00;
    else if (len != 8'hff) len <= len + 8'h01;
  end
  chk_vector_fixed: assert property (IRQ_VECTOR == 24'h000024)
    else $error("vector address wrong");
  chk_reset_idle: assert property (disable iff (1'b0)
    RESET |=> ANALOG_PIN_ENABLE == 4'h0 && !BUSY)
    else $error("not idle after reset");
  chk_pins_copy: assert property (
    wr && PADDR[9:2] == 8'h81 |-> ##2 ANALOG_PIN_ENABLE == pins)
    else $error("pin enables not applied");
  chk_mux_chan: assert property (
    ANALOG_MUX_SEL != 4'h0 |->
      $past(SAMPLE_HOLD) && ANALOG_MUX_SEL == 4'h1 << chan)
    else $error("wrong input routed");
  chk_sample_busy: assert property (SAMPLE_HOLD |-> BUSY)
    else $error("sampling outside conversion");
  chk_dac_msb: assert property (
    $fell(SAMPLE_HOLD) |-> DAC_CODE == 10'h200)
    else $error("first trial not msb");
  chk_dac_idle: assert property (!BUSY |-> DAC_CODE == 10'h000)
    else $error("trial code while idle");
  chk_conv_length: assert property (
    $fell(BUSY) |-> $past(len) >= 8'h16)
    else $error("conversion too short");
  chk_irq_cause: assert property (
    IRQ_REQUEST |-> $past(en) && $past(prio) > $past(CPU_LEVEL))
    else $error("request without cause");
  chk_apb_wait: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready timing wrong");
  cover property ($fell(BUSY));
  cover property (IRQ_REQUEST);
  cover property (ANALOG_MUX_SEL == 4'h8);
endmodule

bind sar_adc_sequencer sar_adc_checker chk_i (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .DAC_CODE(DAC_CODE), .SAMPLE_HOLD(SAMPLE_HOLD),
  .ANALOG_MUX_SEL(ANALOG_MUX_SEL), .ANALOG_PIN_ENABLE(ANALOG_PIN_ENABLE),
  .BUSY(BUSY), .CPU_LEVEL(CPU_LEVEL), .IRQ_REQUEST(IRQ_REQUEST),
  .IRQ_VECTOR(IRQ_VECTOR));

// ==== tb/sar_adc_sequencer_test.sv ====
// self-checking bench for the converter sequencer
// assumes the far-side model drives oscillators and comparator
`include "sar_adc_defs.vh"
module sar_adc_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  cpu_level = 2'h0;
  logic [39:0] levels = {10'h3ff, 10'h155, 10'h2a5, 10'h000};
  wire  [31:0] prdata;
  wire         pready, pslverr, fast, slow, comp, busy, irq, sample;
  wire  [9:0]  dac;
  wire  [3:0]  mux, pins;
  wire  [23:0] vec;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  sar_adc_sequencer sar_adc_sequencer_i (.CLK(clk), .RESET(reset),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FAST_OSC(fast), .SLOW_OSC(slow),
    .COMP_HIGH(comp), .DAC_CODE(dac), .SAMPLE_HOLD(sample),
    .ANALOG_MUX_SEL(mux), .ANALOG_PIN_ENABLE(pins), .BUSY(busy),
    .CPU_LEVEL(cpu_level), .IRQ_REQUEST(irq), .IRQ_VECTOR(vec));
  adc_far_side adc_far_side_i (.clk(clk), .mux_sel(mux), .pin_en(pins),
    .dac_code(dac), .levels(levels), .fast_osc(fast), .slow_osc(slow),
    .comp_high(comp));
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx,
    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    check(what, r, exp);
  endtask
  // busy rises one cycle after the start write completes
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    if (n == 8000) err_total++;
  endtask
  task automatic t_reset_values;
    rd_chk("clock ctrl", `IDX_CLOCK_CTRL, 32'h0);
    rd_chk("pin ctrl", `IDX_PIN_CTRL, 32'h0);
    rd_chk("conv ctrl", `IDX_CONV_CTRL, 32'h0);
    rd_chk("irq prio", `IDX_IRQ_PRIO, 32'h0);
    rd_chk("irq enable", `IDX_IRQ_ENABLE, 32'h0);
    rd_chk("done flag", `IDX_IRQ_FLAG, 32'h0);
    check("pin enables", {28'h0, pins}, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_registers;
    logic [31:0] r;
    logic e;
    wr(`IDX_CLOCK_CTRL, 32'h0e);
    rd_chk("clock ctrl", `IDX_CLOCK_CTRL, 32'h0e);
    wr(`IDX_PIN_CTRL, 32'ha0);
    rd_chk("pin ctrl", `IDX_PIN_CTRL, 32'ha0);
    check("pin enables", {28'h0, pins}, 32'ha);
    wr(`IDX_CONV_CTRL, 32'h03);
    rd_chk("conv ctrl", `IDX_CONV_CTRL, 32'h03);
    check("busy", {31'h0, busy}, 32'h0);
    wr(`IDX_RESULT_HI, 32'hff);
    rd_chk("result high", `IDX_RESULT_HI, 32'h0);
    wr(`IDX_IRQ_PRIO, 32'hff);
    rd_chk("irq prio", `IDX_IRQ_PRIO, 32'hc0);
    apb(1'b0, 8'h85, 32'h0, r, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    wr(`IDX_IRQ_PRIO, 32'h0);
    $display("register access done");
  endtask
  // rising select order: the prescaler count never exceeds its end
  task automatic t_conversions;
    int t0;
    real per;
    logic [9:0] v;
    wr(`IDX_PIN_CTRL, 32'hf0);
    for (int s = 0; s < 8; s++) begin
      v = levels[(s%4)*10 +: 10];
      wr(`IDX_CLOCK_CTRL, {28'h0, 1'b1, s[2:0]});
      wr(`IDX_CONV_CTRL, {24'h0, 6'h20, s[1:0]});
      t0 = cyc;
      wait_idle;
      per = (s == 7) ? 14.8 : 4.4 * (1 << s);
      check("span", {31'h0, (cyc - t0) > 21.0 * per &&
        (cyc - t0) < 22.0 * per + 10.0}, 32'h1);
      rd_chk("result high", `IDX_RESULT_HI, {24'h0, v[9:2]});
      rd_chk("result low", `IDX_RESULT_LO, {30'h0, v[1:0]});
      rd_chk("done flag", `IDX_IRQ_FLAG, 32'h80);
      wr(`IDX_IRQ_FLAG, 32'h0);
      rd_chk("flag kept", `IDX_IRQ_FLAG, 32'h80);
      wr(`IDX_IRQ_FLAG, 32'h80);
      rd_chk("flag cleared", `IDX_IRQ_FLAG, 32'h0);
      rd_chk("result held", `IDX_RESULT_HI, {24'h0, v[9:2]});
    end
    $display("conversions done");
  endtask
  task automatic t_interrupt;
    wr(`IDX_IRQ_ENABLE, 32'h80);
    wr(`IDX_IRQ_PRIO, 32'h80);
    cpu_level <= 2'h1;
    wr(`IDX_CONV_CTRL, 32'h81);
    wait_idle;
    repeat (3) @(posedge clk);
    check("irq above level", {31'h0, irq}, 32'h1);
    cpu_level <= 2'h2;
    repeat (3) @(posedge clk);
    check("irq at level", {31'h0, irq}, 32'h0);
    wr(`IDX_IRQ_PRIO, 32'hc0);
    repeat (2) @(posedge clk);
    check("irq higher prio", {31'h0, irq}, 32'h1);
    wr(`IDX_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    check("irq disabled", {31'h0, irq}, 32'h0);
    wr(`IDX_IRQ_ENABLE, 32'h80);
    wr(`IDX_IRQ_FLAG, 32'h80);
    repeat (2) @(posedge clk);
    check("irq flag cleared", {31'h0, irq}, 32'h0);
    check("vector", {8'h0, vec}, 32'h24);
    $display("interrupt done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset_values;
    t_registers;
    t_conversions;
    t_interrupt;
    wrap_up;
  end
  // about four times the expected run
  initial begin
    #3000000;
    err_total++;
    wrap_up;
  end
endmodule
